// ### rtl/afe_regs_pkg.sv
package afe_regs_pkg;
    // register offsets
    localparam logic [7:0] LINK_AND_READY_CTRL_ADDR = 8'h09;
    localparam logic [7:0] CONVERTER_SETUP_HI_ADDR  = 8'h0A;
    localparam logic [7:0] CONVERTER_SETUP_LO_ADDR  = 8'h0B;
    localparam logic [7:0] PHASE_ADDR               = 8'h07;
    // values after reset
    localparam logic [7:0] LINK_CTRL_RESET = 8'hA3;
    localparam logic [7:0] SETUP_HI_RESET  = 8'h10;
    localparam logic [7:0] SETUP_LO_RESET  = 8'h0C;
    localparam logic [7:0] PHASE_RESET     = 8'h00;
    // field positions in link_and_ready_ctrl
    localparam int ADDR_LOOP_LSB   = 6;
    localparam int SETTLE_LAT_BIT  = 5;
    localparam int DRIVE_SEL_BIT   = 4;
    localparam int SOURCE_SEL_LSB  = 2;
    // field positions in converter_setup_hi / lo
    localparam int DIVIDER_LSB     = 6;
    localparam int OSR_LSB         = 4;
    localparam int WORD_SIZE_LSB   = 2;
    localparam int BITSTREAM_LSB   = 0;
    localparam int HOLD_RESET_LSB  = 6;
    localparam int POWER_DOWN_LSB  = 4;
    localparam int SCRAMBLE_LSB    = 2;
    localparam int REF_SRC_BIT     = 1;
    localparam int CLK_SRC_BIT     = 0;
    // settling periods before the first ready strobe
    localparam logic [1:0] SETTLE_PERIODS = 2'd3;
    // ready pin low time in clock cycles
    localparam logic [1:0] STROBE_CYCLES = 2'd1;
    // address loop codes
    localparam logic [1:0] LOOP_SINGLE = 2'b00;
    localparam logic [1:0] LOOP_GROUP  = 2'b01;
    localparam logic [1:0] LOOP_TYPE   = 2'b10;
    localparam logic [1:0] LOOP_ALL    = 2'b11;
    localparam logic [1:0] SRC_LINKED  = 2'b00;
    localparam logic [7:0] LAST_ADDR   = 8'h0B;
endpackage

// ### rtl/afe_ready_and_config_regs.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module afe_ready_and_config_regs #(
    parameter int DATA_W = 24
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic [7:0]        regAddr,
    input  wire logic [7:0]        regWdata,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [7:0]        regRdata,
    input  wire logic              readStart,
    input  wire logic              addrStep,
    output logic      [7:0]        readAddr,
    input  wire logic              filterRestart,
    input  wire logic              convDone0,
    input  wire logic              convDone1,
    input  wire logic [DATA_W-1:0] convData0,
    input  wire logic [DATA_W-1:0] convData1,
    output logic      [DATA_W-1:0] heldData0,
    output logic      [DATA_W-1:0] heldData1,
    input  wire logic              masterClockIn,
    output logic                   analogMasterClock,
    output logic      [8:0]        oversampleRatio,
    output logic      [1:0]        wordSize24,
    input  wire logic              modBit0,
    input  wire logic              modBit1,
    output logic                   bitstreamPin0,
    output logic                   bitstreamPin1,
    output logic                   bitstreamOe0,
    output logic                   bitstreamOe1,
    output logic      [1:0]        chanInReset,
    output logic      [1:0]        chanPoweredDown,
    output logic      [1:0]        chanDither,
    output logic                   internalRefOff,
    output logic                   oscillatorBypass,
    output logic                   readyStrobeOut_n,
    output logic                   readyStrobeOe
);
    logic [7:0] linkCtrl;
    logic [7:0] setupHi;
    logic [7:0] setupLo;
    logic [7:0] skew;
    logic [1:0] pendingFlags;
    logic [1:0] settleCount;
    logic [1:0] strobeCount;
    logic [2:0] divCount;
    logic       readBusy;

    // link control fields
    wire [1:0] addrLoop    = linkCtrl[afe_regs_pkg::ADDR_LOOP_LSB +: 2];
    wire       settleOn    = linkCtrl[afe_regs_pkg::SETTLE_LAT_BIT];
    wire       driveHigh   = linkCtrl[afe_regs_pkg::DRIVE_SEL_BIT];
    wire [1:0] sourceSel   = linkCtrl[afe_regs_pkg::SOURCE_SEL_LSB +: 2];
    wire       linked      = (sourceSel == afe_regs_pkg::SRC_LINKED);

    // configuration fields
    wire [1:0] divCode     = setupHi[afe_regs_pkg::DIVIDER_LSB +: 2];
    wire [1:0] osrCode     = setupHi[afe_regs_pkg::OSR_LSB +: 2];
    wire [1:0] wordSel     = setupHi[afe_regs_pkg::WORD_SIZE_LSB +: 2];
    wire [1:0] bitSel      = setupHi[afe_regs_pkg::BITSTREAM_LSB +: 2];
    wire [1:0] holdRst     = setupLo[afe_regs_pkg::HOLD_RESET_LSB +: 2];
    wire [1:0] pwrDown     = setupLo[afe_regs_pkg::POWER_DOWN_LSB +: 2];
    wire [1:0] scramble    = setupLo[afe_regs_pkg::SCRAMBLE_LSB +: 2];
    wire       refExt      = setupLo[afe_regs_pkg::REF_SRC_BIT];
    wire       clock_source_sel      = setupLo[afe_regs_pkg::CLK_SRC_BIT];

    // address hits shared by write and read decode
    wire hitLink = (regAddr == afe_regs_pkg::LINK_AND_READY_CTRL_ADDR);
    wire hitHi   = (regAddr == afe_regs_pkg::CONVERTER_SETUP_HI_ADDR);
    wire hitLo   = (regAddr == afe_regs_pkg::CONVERTER_SETUP_LO_ADDR);
    wire hitSkew = (regAddr == afe_regs_pkg::PHASE_ADDR);

    // strobe decode
    wire wrLink  = regWrite && hitLink;
    wire wrHi    = regWrite && hitHi;
    wire wrLo    = regWrite && hitLo;
    wire wrSkew  = regWrite && hitSkew;
    wire rdLink  = regRead && hitLink;

    // channel alive when neither held in reset nor powered down
    wire [1:0] alive     = ~(holdRst | pwrDown);
    wire       bothAlive = &alive;

    // sign bit of the skew field depends on ratio; positive means ch0 lags
    wire skewNeg = skew[3'(4 + osrCode)];
    wire skewPos = !skewNeg && (skew != 8'h00);
    wire lag0    = skewPos;

    // settle gating and the counter step
    wire       settled          = (settleCount == 2'd0);
    wire       settleStep       = !settled && (convDone0 || convDone1);
    wire [1:0] next_settleCount = settleCount - 2'd1;

    // raw events per channel, settled gating applied
    wire ev0      = convDone0 && alive[0] && settled;
    wire ev1      = convDone1 && alive[1] && settled;
    wire lagDone  = lag0 ? convDone0 : convDone1;
    wire lagEvent = lagDone && bothAlive && settled;

    // pin selection per mode
    wire pass0      = !linked && sourceSel[0] && ev0;
    wire pass1      = !linked && sourceSel[1] && ev1;
    wire indepEvent = pass0 || pass1;
    wire pinEvent   = linked ? lagEvent : indepEvent;

    // pending flags, clear wins over the status read set
    wire [1:0] setFlags = {2{rdLink}};
    wire [1:0] clrFlags = linked ? {2{lagEvent}} : {ev1, ev0};
    wire [1:0] next_pendingFlags = (setFlags | pendingFlags) & ~clrFlags;

    // read mux, unmapped reads zero
    wire [7:0] rdLinkVal = {linkCtrl[7:2], pendingFlags};
    wire [7:0] rdMux     = ({8{hitLink}} & rdLinkVal)
                         | ({8{hitHi}} & setupHi)
                         | ({8{hitLo}} & setupLo)
                         | ({8{hitSkew}} & skew);

    // address loop boundaries: groups of three, types channel/config split
    logic [7:0] loopLo;
    logic [7:0] loopHi;
    always_comb begin
        loopLo = readAddr;
        loopHi = readAddr;
        case (addrLoop)
            afe_regs_pkg::LOOP_ALL: begin
                loopLo = 8'h00;
                loopHi = afe_regs_pkg::LAST_ADDR;
            end
            afe_regs_pkg::LOOP_TYPE: begin
                if (readAddr < 8'h06) begin
                    loopLo = 8'h00;
                    loopHi = 8'h05;
                end else begin
                    loopLo = 8'h06;
                    loopHi = afe_regs_pkg::LAST_ADDR;
                end
            end
            afe_regs_pkg::LOOP_GROUP: begin
                if (readAddr < 8'h03) begin
                    loopLo = 8'h00;
                end else if (readAddr < 8'h06) begin
                    loopLo = 8'h03;
                end else if (readAddr < 8'h09) begin
                    loopLo = 8'h06;
                end else begin
                    loopLo = 8'h09;
                end
                loopHi = loopLo + 8'h02;
            end
            default: begin
                loopLo = readAddr;
                loopHi = readAddr;
            end
        endcase
    end

    // next continuous-read address, wrapping inside the loop
    wire [7:0] next_readAddr = (readAddr >= loopHi) ? loopLo : readAddr + 8'h01;

    // divide ratio and master clock divider
    wire [2:0] divMask       = 3'((4'b0001 << divCode) - 4'd1);
    wire       divWrap       = (divCount >= divMask);
    wire [2:0] next_divCount = divWrap ? 3'd0 : divCount + 3'd1;

    // control register, flag bits kept out of storage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            linkCtrl <= afe_regs_pkg::LINK_CTRL_RESET;
        end else if (wrLink) begin
            linkCtrl <= {regWdata[7:2], 2'b00};
        end
    end

    // first configuration register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            setupHi <= afe_regs_pkg::SETUP_HI_RESET;
        end else if (wrHi) begin
            setupHi <= regWdata;
        end
    end

    // second configuration register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            setupLo <= afe_regs_pkg::SETUP_LO_RESET;
        end else if (wrLo) begin
            setupLo <= regWdata;
        end
    end

    // phase register for the lag decision
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            skew <= afe_regs_pkg::PHASE_RESET;
        end else if (wrSkew) begin
            skew <= regWdata;
        end
    end

    // pending flags
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pendingFlags <= 2'b11;
        end else begin
            pendingFlags <= next_pendingFlags;
        end
    end

    // read data for one cycle after the strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= regRead ? rdMux : 8'h00;
        end
    end

    // settle counter restarted by filter restart
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            settleCount <= afe_regs_pkg::SETTLE_PERIODS;
        end else if (filterRestart) begin
            settleCount <= settleOn ? afe_regs_pkg::SETTLE_PERIODS : 2'd0;
        end else if (settleStep) begin
            settleCount <= next_settleCount;
        end
    end

    // read transaction tracking and continuous-read address
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readBusy <= 1'b0;
            readAddr <= 8'h00;
        end else begin
            if (readStart) begin
                readBusy <= 1'b1;
            end else if (regRead && !addrStep) begin
                readBusy <= 1'b0;
            end
            if (readStart) begin
                readAddr <= regAddr;
            end else if (addrStep) begin
                readAddr <= next_readAddr;
            end
        end
    end

    // capture enables, closed while a read is in progress
    wire captureOpen = !readBusy && !readStart;
    wire take0       = captureOpen && (linked ? lagEvent : ev0);
    wire take1       = captureOpen && (linked ? lagEvent : ev1);

    // data capture
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            heldData0 <= '0;
            heldData1 <= '0;
        end else begin
            if (take0) begin
                heldData0 <= convData0;
            end
            if (take1) begin
                heldData1 <= convData1;
            end
        end
    end

    // ready pin pulse length and inactive drive
    wire       lowNow           = pinEvent || (strobeCount > 2'd1);
    wire [1:0] next_strobeCount = pinEvent ? afe_regs_pkg::STROBE_CYCLES :
                                  (strobeCount != 2'd0) ? strobeCount - 2'd1 : 2'd0;

    // ready pin flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strobeCount      <= 2'd0;
            readyStrobeOut_n <= 1'b1;
            readyStrobeOe    <= 1'b0;
        end else begin
            strobeCount      <= next_strobeCount;
            readyStrobeOut_n <= !lowNow;
            readyStrobeOe    <= lowNow || driveHigh;
        end
    end

    // analog master clock divider
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            divCount          <= 3'd0;
            analogMasterClock <= 1'b0;
        end else if (masterClockIn) begin
            divCount          <= next_divCount;
            analogMasterClock <= (divCount == 3'd0);
        end else begin
            analogMasterClock <= 1'b0;
        end
    end

    // ratio and word size outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oversampleRatio <= 9'd64;
            wordSize24      <= 2'b00;
        end else begin
            oversampleRatio <= 9'(9'd32 << osrCode);
            wordSize24      <= wordSel;
        end
    end

    // bitstream pins and their enables
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bitstreamPin0 <= 1'b0;
            bitstreamPin1 <= 1'b0;
            bitstreamOe0  <= 1'b0;
            bitstreamOe1  <= 1'b0;
        end else begin
            bitstreamPin0 <= bitSel[0] && modBit0;
            bitstreamPin1 <= bitSel[1] && modBit1;
            bitstreamOe0  <= bitSel[0];
            bitstreamOe1  <= bitSel[1];
        end
    end

    // channel reset, power-down and dither
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chanInReset     <= 2'b00;
            chanPoweredDown <= 2'b00;
            chanDither      <= 2'b11;
        end else begin
            chanInReset     <= holdRst;
            chanPoweredDown <= pwrDown;
            chanDither      <= scramble;
        end
    end

    // reference and clock source
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            internalRefOff   <= 1'b0;
            oscillatorBypass <= 1'b0;
        end else begin
            internalRefOff   <= refExt;
            oscillatorBypass <= clock_source_sel;
        end
    end
endmodule

// ### tb/afe_regs_monitor.sv
`timescale 1ns/1ps
module afe_regs_monitor (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWrite,
    input wire logic       convDone0,
    input wire logic       convDone1,
    input wire logic [8:0] oversampleRatio,
    input wire logic [1:0] chanInReset,
    input wire logic [1:0] chanPoweredDown,
    input wire logic [1:0] chanDither,
    input wire logic       internalRefOff,
    input wire logic       readyStrobeOut_n,
    input wire logic       readyStrobeOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ready pin: one-cycle low pulse, caused by a conversion, driven while low
    property p_strobeOne; $fell(readyStrobeOut_n) |=> readyStrobeOut_n; endproperty
    a_strobeOne: assert property (p_strobeOne) else $error("ready pin low too long");
    property p_strobeCause; $fell(readyStrobeOut_n) |-> $past(convDone0) || $past(convDone1); endproperty
    a_strobeCause: assert property (p_strobeCause) else $error("ready pulse without conversion");
    property p_lowDriven; !readyStrobeOut_n |-> readyStrobeOe; endproperty
    a_lowDriven: assert property (p_lowDriven) else $error("ready low while released");
    // ratio output only takes the four legal values
    property p_osrLegal; oversampleRatio inside {9'd32, 9'd64, 9'd128, 9'd256}; endproperty
    a_osrLegal: assert property (p_osrLegal) else $error("illegal oversample ratio");
    // no ready pulse while both channels are held or both are powered down
    property p_bothReset; (chanInReset == 2'b11) && ($past(chanInReset) == 2'b11) |-> readyStrobeOut_n; endproperty
    a_bothReset: assert property (p_bothReset) else $error("ready pulse with both held");
    property p_bothDown; (chanPoweredDown == 2'b11) [*2] |-> readyStrobeOut_n; endproperty
    a_bothDown: assert property (p_bothDown) else $error("ready pulse with both down");
    // configuration outputs follow a write two cycles later
    property p_ditherFollow; regWrite && (regAddr == afe_regs_pkg::CONVERTER_SETUP_LO_ADDR)
        |-> ##2 chanDither == 2'($past(regWdata, 2) >> 2); endproperty
    a_ditherFollow: assert property (p_ditherFollow) else $error("dither output stale");
    property p_refFollow; regWrite && (regAddr == afe_regs_pkg::CONVERTER_SETUP_LO_ADDR)
        |=> ##1 internalRefOff == 1'($past(regWdata, 2) >> 1); endproperty
    a_refFollow: assert property (p_refFollow) else $error("reference output stale");
endmodule
bind afe_ready_and_config_regs afe_regs_monitor mon_u (
    .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .convDone0(convDone0), .convDone1(convDone1), .oversampleRatio(oversampleRatio), .chanInReset(chanInReset),
    .chanPoweredDown(chanPoweredDown), .chanDither(chanDither), .internalRefOff(internalRefOff),
    .readyStrobeOut_n(readyStrobeOut_n), .readyStrobeOe(readyStrobeOe));

// ### tb/conv_model.sv
`timescale 1ns/1ps
module conv_model (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [1:0]  kick,
    output logic             convDone0,
    output logic             convDone1,
    output logic      [23:0] convData0,
    output logic      [23:0] convData1,
    output logic             modBit0,
    output logic             modBit1,
    output logic             masterClockIn
);
    // one conversion per kick, new word with its done pulse; bitstreams toggle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {convDone1, convDone0} <= 2'b00;
            convData0 <= 24'h10_0000;
            convData1 <= 24'h20_0000;
            {modBit1, modBit0, masterClockIn} <= 3'b010;
        end else begin
            {convDone1, convDone0} <= kick;
            convData0 <= convData0 + {23'h0, kick[0]};
            convData1 <= convData1 + {23'h0, kick[1]};
            {modBit1, modBit0, masterClockIn} <= ~{modBit1, modBit0, masterClockIn};
        end
    end
endmodule

// ### tb/afe_ready_and_config_regs_test.sv
`timescale 1ns/1ps
module afe_ready_and_config_regs_test;
    logic        clk, reset_n, regWrite, regRead, readStart, addrStep, filterRestart, convDone0, convDone1;
    logic        modBit0, modBit1, masterClockIn, bitstreamOe0, bitstreamOe1, readyStrobeOut_n, readyStrobeOe;
    logic        internalRefOff, oscillatorBypass, analogMasterClock, bitstreamPin0, bitstreamPin1;
    logic [7:0]  regAddr, regWdata, regRdata, readAddr;
    logic [1:0]  kick, wordSize24, chanInReset, chanPoweredDown, chanDither;
    logic [23:0] convData0, convData1, heldData0, heldData1, keep0;
    logic [8:0]  oversampleRatio;
    logic [7:0]  loopExp [4] = '{8'h0B, 8'h09, 8'h06, 8'h00};
    int          mismatches, totalChecks, n0, n1, c, ticks;
    afe_ready_and_config_regs #(.DATA_W(24)) dut_u (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .readStart(readStart),
        .addrStep(addrStep), .readAddr(readAddr), .filterRestart(filterRestart), .convDone0(convDone0),
        .convDone1(convDone1), .convData0(convData0), .convData1(convData1), .heldData0(heldData0),
        .heldData1(heldData1), .masterClockIn(masterClockIn), .analogMasterClock(analogMasterClock),
        .oversampleRatio(oversampleRatio), .wordSize24(wordSize24), .modBit0(modBit0), .modBit1(modBit1),
        .bitstreamPin0(bitstreamPin0), .bitstreamPin1(bitstreamPin1),
        .bitstreamOe0(bitstreamOe0), .bitstreamOe1(bitstreamOe1), .chanInReset(chanInReset),
        .chanPoweredDown(chanPoweredDown), .chanDither(chanDither), .internalRefOff(internalRefOff),
        .oscillatorBypass(oscillatorBypass), .readyStrobeOut_n(readyStrobeOut_n), .readyStrobeOe(readyStrobeOe));
    conv_model conv_u (.clk(clk), .reset_n(reset_n), .kick(kick), .convDone0(convDone0), .convDone1(convDone1),
        .convData0(convData0), .convData1(convData1), .modBit0(modBit0), .modBit1(modBit1),
        .masterClockIn(masterClockIn));
    // 25 MHz clock
    always #20 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic settle;
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) {regAddr, regWdata, regWrite} <= {a, d, 1'b1};
        @(posedge clk) regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) {regAddr, regRead} <= {a, 1'b1};
        @(posedge clk) regRead <= 1'b0;
        #1 check({24'h0, regRdata}, {24'h0, e});
    endtask
    // one conversion on the kicked channels, then look for a ready pulse
    task automatic fire(input logic [1:0] k, input logic expLow);
        logic seen;
        seen = 1'b0;
        n0 += k[0];
        n1 += k[1];
        @(posedge clk) kick <= k;
        @(posedge clk) kick <= 2'b00;
        repeat (4) begin
            settle();
            if (readyStrobeOut_n === 1'b0) seen = 1'b1;
        end
        check({31'h0, seen}, {31'h0, expLow});
    endtask
    task automatic loopStep(input logic [7:0] e);
        @(posedge clk) {regAddr, readStart} <= {8'h0B, 1'b1};
        @(posedge clk) {readStart, addrStep} <= 2'b01;
        @(posedge clk) addrStep <= 1'b0;
        #1 check({24'h0, readAddr}, {24'h0, e});
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        {regWrite, regRead, readStart, addrStep, filterRestart, regAddr, regWdata, kick} = '0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        rd(afe_regs_pkg::LINK_AND_READY_CTRL_ADDR, 8'hA3);
        rd(afe_regs_pkg::CONVERTER_SETUP_HI_ADDR, 8'h10);
        rd(afe_regs_pkg::CONVERTER_SETUP_LO_ADDR, 8'h0C);
        rd(8'h20, 8'h00);
        for (c = 0; c < 4; c++) begin
            wr(afe_regs_pkg::CONVERTER_SETUP_HI_ADDR, {2'b00, c[1:0], 4'hF});
            settle();
            check({23'h0, oversampleRatio}, 32'd32 << c);
        end
        check({wordSize24, bitstreamOe1, bitstreamOe0}, 4'hF);
        check({30'h0, bitstreamPin1, bitstreamPin0}, {30'h0, ~modBit1, ~modBit0});
        wr(afe_regs_pkg::CONVERTER_SETUP_LO_ADDR, 8'hF3);
        rd(afe_regs_pkg::CONVERTER_SETUP_LO_ADDR, 8'hF3);
        check({chanInReset, chanPoweredDown, chanDither, internalRefOff, oscillatorBypass}, 8'hF3);
        wr(afe_regs_pkg::CONVERTER_SETUP_LO_ADDR, 8'h0C);
        // master clock ticks every other cycle at divider code 0, halving per code: 8, 4, 2, 1 ticks per 16 cycles
        for (c = 0; c < 4; c++) begin
            wr(afe_regs_pkg::CONVERTER_SETUP_HI_ADDR, {c[1:0], 6'h10});
            ticks = 0;
            repeat (16) settle();
            repeat (16) begin
                settle();
                ticks += analogMasterClock;
            end
            check(ticks, 8 >> c);
        end
        wr(afe_regs_pkg::CONVERTER_SETUP_HI_ADDR, 8'h10);
        settle();
        check({bitstreamOe1, bitstreamOe0, bitstreamPin1, bitstreamPin0}, 4'h0);
        // settling latency with channel 0 routed, pin released while idle
        wr(afe_regs_pkg::LINK_AND_READY_CTRL_ADDR, 8'hA4);
        @(posedge clk) filterRestart <= 1'b1;
        @(posedge clk) filterRestart <= 1'b0;
        check({31'h0, readyStrobeOe}, 32'h0);
        repeat (3) fire(2'b01, 1'b0);
        fire(2'b01, 1'b1);
        wr(afe_regs_pkg::LINK_AND_READY_CTRL_ADDR, 8'h90);
        settle();
        check({readyStrobeOe, readyStrobeOut_n}, 2'b11);
        rd(afe_regs_pkg::LINK_AND_READY_CTRL_ADDR, 8'h92);
        for (c = 1; c < 4; c++) begin
            wr(afe_regs_pkg::LINK_AND_READY_CTRL_ADDR, 8'h90 | {4'h0, c[1:0], 2'b00});
            fire(2'b01, c[0]);
            fire(2'b10, c[1]);
            rd(afe_regs_pkg::LINK_AND_READY_CTRL_ADDR, 8'h90 | {4'h0, c[1:0], 2'b00});
        end
        // linked mode, zero skew: channel 1 lags
        wr(afe_regs_pkg::LINK_AND_READY_CTRL_ADDR, 8'h90);
        fire(2'b01, 1'b0);
        rd(afe_regs_pkg::LINK_AND_READY_CTRL_ADDR, 8'h93);
        fire(2'b10, 1'b1);
        check({heldData1, heldData0[23:16]}, {24'h20_0000 + n1[23:0], 8'h10});
        check({8'h0, heldData0}, 32'h0010_0000 + n0);
        rd(afe_regs_pkg::LINK_AND_READY_CTRL_ADDR, 8'h90);
        wr(afe_regs_pkg::PHASE_ADDR, 8'h01);
        fire(2'b10, 1'b0);
        fire(2'b01, 1'b1);
        keep0 = heldData0;
        @(posedge clk) {regAddr, readStart} <= {8'h00, 1'b1};
        @(posedge clk) readStart <= 1'b0;
        fire(2'b01, 1'b1);
        check({8'h0, heldData0}, {8'h0, keep0});
        rd(afe_regs_pkg::LINK_AND_READY_CTRL_ADDR, 8'h90);
        for (c = 0; c < 4; c++) begin
            wr(afe_regs_pkg::LINK_AND_READY_CTRL_ADDR, {c[1:0], 6'h10});
            loopStep(loopExp[c]);
        end
        // channel 0 held: linked mode silent, independent mode keeps channel 1
        wr(afe_regs_pkg::LINK_AND_READY_CTRL_ADDR, 8'h90);
        wr(afe_regs_pkg::CONVERTER_SETUP_LO_ADDR, 8'h4C);
        fire(2'b10, 1'b0);
        fire(2'b01, 1'b0);
        wr(afe_regs_pkg::LINK_AND_READY_CTRL_ADDR, 8'h9C);
        fire(2'b10, 1'b1);
        fire(2'b01, 1'b0);
        wr(afe_regs_pkg::CONVERTER_SETUP_LO_ADDR, 8'h3C);
        fire(2'b11, 1'b0);
        wr(afe_regs_pkg::CONVERTER_SETUP_LO_ADDR, 8'hCC);
        fire(2'b11, 1'b0);
        complete_run();
    end
endmodule
